/* File: hw/pmm_bcd_neg.v */
// packed decimal negate of one byte with extend borrow
`include "pmm_consts.vh"
module pmm_bcd_neg (
  input  wire [7:0] dst,
  input  wire       x_in,
  output reg  [7:0] res,
  output reg        borrow
);
  reg [4:0] lo;
  reg [4:0] hi;
  reg       blo;
  // nibble-wise subtraction from zero with decimal correction
  always @* begin
    lo = 5'h00 - {1'b0, dst[3:0]} - {4'h0, x_in};
    blo = lo[4];
    if (blo) begin
      lo = lo - 5'h06;
    end
    hi = 5'h00 - {1'b0, dst[7:4]} - {4'h0, blo};
    borrow = hi[4];
    if (borrow) begin
      hi = hi - 5'h06;
    end
    res = {hi[3:0], lo[3:0]};
  end
endmodule

/* File: hw/pmm_consts.vh */
// constants for the privileged move / multiply execution unit
`ifndef PMM_CONSTS_VH
`define PMM_CONSTS_VH
// operation codes presented on op
`define PMM_OP_LOW_POWER_STOP   5'h00
`define PMM_OP_LSL      5'h01
`define PMM_OP_LSR      5'h02
`define PMM_OP_RD_SR    5'h03
`define PMM_OP_WR_SR    5'h04
`define PMM_OP_RD_USP   5'h05
`define PMM_OP_WR_USP   5'h06
`define PMM_OP_RD_CR    5'h07
`define PMM_OP_WR_CR    5'h08
`define PMM_OP_ALT_WR   5'h09
`define PMM_OP_ALT_RD   5'h0A
`define PMM_OP_MM_ST    5'h0B
`define PMM_OP_MM_LD    5'h0C
`define PMM_OP_QUICK    5'h0D
`define PMM_OP_UNSIGNED_MULTIPLY_W   5'h0E
`define PMM_OP_SIGNED_MULTIPLY_W   5'h0F
`define PMM_OP_UNSIGNED_MULTIPLY_L   5'h10
`define PMM_OP_SIGNED_MULTIPLY_L   5'h11
`define PMM_OP_UNSIGNED_MULTIPLY_LL  5'h12
`define PMM_OP_SIGNED_MULTIPLY_LL  5'h13
`define PMM_OP_DECIMAL_NEGATE     5'h14
`define PMM_OP_RD_CCR   5'h15
`define PMM_OP_WR_CCR   5'h16
// status register fields
`define PMM_SR_S        13
`define PMM_SR_IPL_LO   8
`define PMM_SR_X        4
`define PMM_SR_N        3
`define PMM_SR_Z        2
`define PMM_SR_V        1
`define PMM_SR_C        0
`define PMM_SR_RESET    16'h2700
// register file and control register map
`define PMM_NREGS       16
`define PMM_CR_SFC      2'h0
`define PMM_CR_DFC      2'h1
`define PMM_CR_VBR      2'h2
// mmio-style software port
`define PMM_A_STAT      4'h0
`define PMM_A_MASK      4'h1
`define PMM_A_SR        4'h2
`define PMM_A_USP       4'h3
`define PMM_A_IMASK     4'h4
`define PMM_A_SFC       4'h5
`define PMM_A_DFC       4'h6
`define PMM_A_VBR       4'h7
// event bits
`define PMM_EV_TRAP     0
`define PMM_EV_STOP     1
`define PMM_EV_DONE     2
`define PMM_NEV         3
// state codes
`define PMM_ST_IDLE     3'h0
`define PMM_ST_MEM      3'h1
`define PMM_ST_MMREG    3'h2
`define PMM_ST_WB       3'h3
`define PMM_ST_STOP     3'h4
`endif

/* File: hw/pmm_core.v */
// execution unit for privileged alternate_space_move, shifts, multiply and decimal negate
// Functional notes
// - low power stop: supervisor loads sr, exports mask, stops; user traps
// - logical shifts by register or immediate count, in a register or in memory
// - reading full status register only in supervisor, else trap
// - writing full status register only in supervisor, else trap unchanged
// - user stack pointer transfers only in supervisor, else trap
// - alternate space move privileged, uses dfc for writes, sfc for reads
// - multiple register move stores or loads listed registers at address
// - quick move writes sign-extended immediate into data register
// - multiply word 16x16->32, long ->32, long ->64 in register pair
// - decimal negate: zero minus destination minus extend, written back
`include "pmm_consts.vh"
module pmm_core #(
  parameter NREGS = `PMM_NREGS
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        clk_en,
  // instruction issue
  input  wire        issue,
  input  wire [4:0]  op,
  input  wire [3:0]  reg_a,
  input  wire [3:0]  reg_b,
  input  wire [1:0]  size,
  input  wire        use_imm,
  input  wire [31:0] imm,
  input  wire [31:0] ea,
  input  wire [15:0] reg_list,
  input  wire        ea_is_reg,
  input  wire        wake,
  // memory side
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  output reg         mem_req,
  output reg         mem_we,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  output reg  [2:0]  mem_fc,
  // status to pipeline
  output reg         busy,
  output reg         trap,
  output reg         stopped,
  output reg  [2:0]  ebi_int_mask,
  // software port
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  output reg         irq
);
  reg [31:0] regs [0:NREGS-1];
  reg [15:0] sr_q;
  reg [31:0] usp_q;
  reg [2:0]  sfc_q;
  reg [2:0]  dfc_q;
  reg [31:0] vbr_q;
  reg [2:0]  st_q;
  reg [`PMM_NEV-1:0] stat_q;
  reg [`PMM_NEV-1:0] mask_q;
  reg [4:0]  op_q;
  reg [3:0]  ra_q;
  reg [3:0]  rb_q;
  reg [1:0]  size_q;
  reg [15:0] list_q;
  reg        mem_op_q;
  reg [`PMM_NEV-1:0] ev;
  reg [31:0] res_d;
  reg [31:0] res_hi_d;
  reg [4:0]  ccr_d;
  integer    i;

  wire       sup = sr_q[`PMM_SR_S];
  wire [31:0] a_val = regs[reg_a];
  wire [31:0] b_val = regs[reg_b];
  wire [5:0] shcnt = use_imm ? {3'h0, (imm[2:0] == 3'h0) ? 3'h0 : imm[2:0]} +
                     {2'h0, (use_imm && imm[2:0] == 3'h0) ? 4'h8 : 4'h0} : a_val[5:0];
  wire [31:0] src = use_imm ? imm : a_val;
  wire [7:0] decimal_negate_res;
  wire       decimal_negate_b;

  // privileged operations need supervisor state
  function is_priv;
    input [4:0] o;
    begin
      is_priv = (o == `PMM_OP_LOW_POWER_STOP) || (o == `PMM_OP_RD_SR) || (o == `PMM_OP_WR_SR) ||
                (o == `PMM_OP_RD_USP) || (o == `PMM_OP_WR_USP) || (o == `PMM_OP_RD_CR) ||
                (o == `PMM_OP_WR_CR) || (o == `PMM_OP_ALT_WR) || (o == `PMM_OP_ALT_RD);
    end
  endfunction

  // mask a value to the operand size
  function [31:0] szmask;
    input [1:0]  s;
    input [31:0] v;
    begin
      case (s)
        2'h0:    szmask = {24'h0, v[7:0]};
        2'h1:    szmask = {16'h0, v[15:0]};
        default: szmask = v;
      endcase
    end
  endfunction

  // sign bit of a value at the operand size
  function msb;
    input [1:0]  s;
    input [31:0] v;
    begin
      case (s)
        2'h0:    msb = v[7];
        2'h1:    msb = v[15];
        default: msb = v[31];
      endcase
    end
  endfunction

  pmm_bcd_neg u_bcd (
    .dst    ((st_q == `PMM_ST_MEM) ? mem_rdata[7:0] : b_val[7:0]),
    .x_in   (sr_q[`PMM_SR_X]),
    .res    (decimal_negate_res),
    .borrow (decimal_negate_b)
  );

  // arithmetic datapath on register operands (memory forms reuse it later)
  reg [63:0] prod;
  reg [32:0] shv;
  reg [31:0] dv;
  always @* begin
    res_d = 32'h0;
    res_hi_d = 32'h0;
    ccr_d = sr_q[4:0];
    prod = 64'h0;
    shv = 33'h0;
    dv = (st_q == `PMM_ST_MEM) ? mem_rdata : b_val;
    case (op)
      `PMM_OP_LSL, `PMM_OP_LSR: begin
        if (op == `PMM_OP_LSL) begin
          shv = {1'b0, szmask(size, dv)} << shcnt;
          case (size)
            2'h0: ccr_d[`PMM_SR_C] = (shcnt != 6'h0) & shv[8];
            2'h1: ccr_d[`PMM_SR_C] = (shcnt != 6'h0) & shv[16];
            default: ccr_d[`PMM_SR_C] = (shcnt != 6'h0) & shv[32];
          endcase
        end else begin
          shv = {szmask(size, dv), 1'b0} >> shcnt;
          ccr_d[`PMM_SR_C] = (shcnt != 6'h0) & shv[0];
        end
        res_d = szmask(size, (op == `PMM_OP_LSL) ? shv[31:0] : shv[32:1]);
        if (shcnt != 6'h0) begin
          ccr_d[`PMM_SR_X] = ccr_d[`PMM_SR_C];
        end
        ccr_d[`PMM_SR_V] = 1'b0;
      end
      `PMM_OP_UNSIGNED_MULTIPLY_W: begin
        prod = {32'h0, {16'h0, src[15:0]} * {16'h0, b_val[15:0]}};
        res_d = prod[31:0];
      end
      `PMM_OP_SIGNED_MULTIPLY_W: begin
        // sign-extend first: a signed product inside a concatenation keeps only 16 bits
        prod = {32'h0, {{16{src[15]}}, src[15:0]} * {{16{b_val[15]}}, b_val[15:0]}};
        res_d = prod[31:0];
      end
      `PMM_OP_UNSIGNED_MULTIPLY_L, `PMM_OP_UNSIGNED_MULTIPLY_LL: begin
        prod = {32'h0, src} * {32'h0, b_val};
        res_d = prod[31:0];
        res_hi_d = prod[63:32];
        ccr_d[`PMM_SR_V] = (op == `PMM_OP_UNSIGNED_MULTIPLY_L) && (prod[63:32] != 32'h0);
      end
      `PMM_OP_SIGNED_MULTIPLY_L, `PMM_OP_SIGNED_MULTIPLY_LL: begin
        prod = $signed({{32{src[31]}}, src}) * $signed({{32{b_val[31]}}, b_val});
        res_d = prod[31:0];
        res_hi_d = prod[63:32];
        ccr_d[`PMM_SR_V] = (op == `PMM_OP_SIGNED_MULTIPLY_L) && (prod[63:32] != {32{prod[31]}});
      end
      `PMM_OP_QUICK: begin
        res_d = {{24{imm[7]}}, imm[7:0]};
        ccr_d[`PMM_SR_V] = 1'b0;
      end
      `PMM_OP_DECIMAL_NEGATE: begin
        res_d = {dv[31:8], decimal_negate_res};
        ccr_d[`PMM_SR_C] = decimal_negate_b;
        ccr_d[`PMM_SR_X] = decimal_negate_b;
      end
      default: res_d = 32'h0;
    endcase
    if (op == `PMM_OP_UNSIGNED_MULTIPLY_LL || op == `PMM_OP_SIGNED_MULTIPLY_LL) begin
      ccr_d[`PMM_SR_N] = prod[63];
      ccr_d[`PMM_SR_Z] = (prod == 64'h0);
      ccr_d[`PMM_SR_C] = 1'b0;
    end else if (op == `PMM_OP_DECIMAL_NEGATE) begin
      if (decimal_negate_res != 8'h00) begin
        ccr_d[`PMM_SR_Z] = 1'b0; // z only cleared, never set
      end
    end else if (op != `PMM_OP_LSL && op != `PMM_OP_LSR) begin
      ccr_d[`PMM_SR_N] = msb((op == `PMM_OP_QUICK || op[4]) ? 2'h2 : 2'h2, res_d);
      ccr_d[`PMM_SR_Z] = (res_d == 32'h0);
      ccr_d[`PMM_SR_C] = 1'b0;
    end else begin
      ccr_d[`PMM_SR_N] = msb(size, res_d);
      ccr_d[`PMM_SR_Z] = (res_d == 32'h0);
    end
  end

  // lowest listed register still to move
  reg [3:0] nxt;
  always @* begin
    nxt = 4'h0;
    for (i = NREGS - 1; i >= 0; i = i - 1) begin
      if (list_q[i]) begin
        nxt = i[3:0];
      end
    end
  end

  // events for the sticky status word
  always @* begin
    ev = {`PMM_NEV{1'b0}};
    if (clk_en && st_q == `PMM_ST_IDLE && issue) begin
      ev[`PMM_EV_TRAP] = is_priv(op) && !sup;
      ev[`PMM_EV_STOP] = (op == `PMM_OP_LOW_POWER_STOP) && sup;
      ev[`PMM_EV_DONE] = !(is_priv(op) && !sup);
    end
  end

  // main sequencer; trapped instructions only raise trap and leave state alone
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sr_q <= `PMM_SR_RESET;
      usp_q <= 32'h0;
      sfc_q <= 3'h0;
      dfc_q <= 3'h0;
      vbr_q <= 32'h0;
      st_q <= `PMM_ST_IDLE;
      op_q <= 5'h0;
      ra_q <= 4'h0;
      rb_q <= 4'h0;
      size_q <= 2'h0;
      list_q <= 16'h0;
      mem_op_q <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 32'h0;
      mem_fc <= 3'h0;
      busy <= 1'b0;
      trap <= 1'b0;
      stopped <= 1'b0;
      ebi_int_mask <= 3'h7;
      for (i = 0; i < NREGS; i = i + 1) begin
        regs[i] <= 32'h0;
      end
    end else if (clk_en) begin
      trap <= 1'b0;
      case (st_q)
        `PMM_ST_IDLE: begin
          if (issue) begin
            op_q <= op;
            ra_q <= reg_a;
            rb_q <= reg_b;
            size_q <= size;
            if (is_priv(op) && !sup) begin
              trap <= 1'b1;
            end else begin
              case (op)
                `PMM_OP_LOW_POWER_STOP: begin
                  sr_q <= imm[15:0];
                  ebi_int_mask <= imm[`PMM_SR_IPL_LO+2:`PMM_SR_IPL_LO];
                  stopped <= 1'b1;
                  busy <= 1'b1;
                  st_q <= `PMM_ST_STOP;
                end
                `PMM_OP_RD_SR: regs[reg_b] <= {16'h0, sr_q};
                `PMM_OP_WR_SR: sr_q <= src[15:0];
                `PMM_OP_RD_CCR: regs[reg_b] <= {27'h0, sr_q[4:0]};
                `PMM_OP_WR_CCR: sr_q[4:0] <= src[4:0];
                `PMM_OP_RD_USP: regs[reg_b] <= usp_q;
                `PMM_OP_WR_USP: usp_q <= a_val;
                `PMM_OP_RD_CR: begin
                  case (imm[1:0])
                    `PMM_CR_SFC: regs[reg_b] <= {29'h0, sfc_q};
                    `PMM_CR_DFC: regs[reg_b] <= {29'h0, dfc_q};
                    `PMM_CR_VBR: regs[reg_b] <= vbr_q;
                    default:     regs[reg_b] <= usp_q;
                  endcase
                end
                `PMM_OP_WR_CR: begin
                  case (imm[1:0])
                    `PMM_CR_SFC: sfc_q <= a_val[2:0];
                    `PMM_CR_DFC: dfc_q <= a_val[2:0];
                    `PMM_CR_VBR: vbr_q <= a_val;
                    default:     usp_q <= a_val;
                  endcase
                end
                `PMM_OP_ALT_WR, `PMM_OP_ALT_RD, `PMM_OP_MM_ST, `PMM_OP_MM_LD: begin
                  // alternate space picks dfc for writes, sfc for reads
                  mem_fc <= (op == `PMM_OP_ALT_WR) ? dfc_q : (op == `PMM_OP_ALT_RD) ? sfc_q :
                            (sup ? 3'h5 : 3'h1);
                  mem_addr <= ea;
                  busy <= 1'b1;
                  if (op == `PMM_OP_MM_ST || op == `PMM_OP_MM_LD) begin
                    list_q <= reg_list;
                    st_q <= (reg_list == 16'h0) ? `PMM_ST_IDLE : `PMM_ST_MMREG;
                    busy <= (reg_list != 16'h0);
                  end else begin
                    mem_req <= 1'b1;
                    mem_we <= (op == `PMM_OP_ALT_WR);
                    mem_wdata <= a_val;
                    st_q <= `PMM_ST_MEM;
                  end
                end
                `PMM_OP_LSL, `PMM_OP_LSR, `PMM_OP_DECIMAL_NEGATE: begin
                  if (ea_is_reg) begin
                    regs[reg_b] <= res_d;
                    sr_q[4:0] <= ccr_d;
                  end else begin
                    // memory form: read, modify, write back
                    mem_fc <= sup ? 3'h5 : 3'h1;
                    mem_addr <= ea;
                    mem_req <= 1'b1;
                    mem_we <= 1'b0;
                    busy <= 1'b1;
                    st_q <= `PMM_ST_MEM;
                  end
                end
                `PMM_OP_QUICK, `PMM_OP_UNSIGNED_MULTIPLY_W, `PMM_OP_SIGNED_MULTIPLY_W, `PMM_OP_UNSIGNED_MULTIPLY_L, `PMM_OP_SIGNED_MULTIPLY_L: begin
                  regs[reg_b] <= res_d;
                  sr_q[4:0] <= ccr_d;
                end
                `PMM_OP_UNSIGNED_MULTIPLY_LL, `PMM_OP_SIGNED_MULTIPLY_LL: begin
                  regs[reg_b] <= res_d; // low half in dl, high in dh
                  regs[reg_a] <= res_hi_d;
                  sr_q[4:0] <= ccr_d;
                end
                default: ;
              endcase
            end
          end
        end
        `PMM_ST_MMREG: begin
          // one register per memory cycle, lowest listed first
          mem_req <= 1'b1;
          mem_we <= (op_q == `PMM_OP_MM_ST);
          mem_wdata <= regs[nxt];
          ra_q <= nxt;
          list_q[nxt] <= 1'b0;
          st_q <= `PMM_ST_MEM;
          mem_op_q <= 1'b1;
        end
        `PMM_ST_MEM: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            if (mem_op_q) begin
              if (op_q == `PMM_OP_MM_LD) begin
                regs[ra_q] <= mem_rdata;
              end
              mem_addr <= mem_addr + 32'h4;
              mem_op_q <= (list_q != 16'h0);
              st_q <= (list_q != 16'h0) ? `PMM_ST_MMREG : `PMM_ST_IDLE;
              busy <= (list_q != 16'h0);
            end else if (op_q == `PMM_OP_ALT_RD) begin
              regs[rb_q] <= mem_rdata;
              busy <= 1'b0;
              st_q <= `PMM_ST_IDLE;
            end else if (op_q == `PMM_OP_ALT_WR || mem_we) begin
              busy <= 1'b0;
              st_q <= `PMM_ST_IDLE;
            end else begin
              st_q <= `PMM_ST_WB;
              mem_wdata <= (op_q == `PMM_OP_DECIMAL_NEGATE) ? res_d : {31'h0, 1'b0} | res_d;
              sr_q[4:0] <= ccr_d; // flags only while the read operand is on mem_rdata
            end
          end
        end
        `PMM_ST_WB: begin
          mem_req <= 1'b1; // write result back to memory
          mem_we <= 1'b1;
          st_q <= `PMM_ST_MEM;
        end
        `PMM_ST_STOP: begin
          if (wake) begin
            stopped <= 1'b0;
            busy <= 1'b0;
            st_q <= `PMM_ST_IDLE;
          end
        end
        default: st_q <= `PMM_ST_IDLE;
      endcase
    end
  end

  // software port: sticky status, mask, irq; set wins over write-one-clear
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_q <= {`PMM_NEV{1'b0}};
      mask_q <= {`PMM_NEV{1'b0}};
      rdata <= 32'h0;
      irq <= 1'b0;
    end else if (clk_en) begin
      stat_q <= (stat_q & ~((wr && addr == `PMM_A_STAT) ? wdata[`PMM_NEV-1:0] : {`PMM_NEV{1'b0}})) | ev;
      if (wr && addr == `PMM_A_MASK) begin
        mask_q <= wdata[`PMM_NEV-1:0];
      end
      irq <= |(((stat_q & ~((wr && addr == `PMM_A_STAT) ? wdata[`PMM_NEV-1:0] : {`PMM_NEV{1'b0}})) | ev) &
               ((wr && addr == `PMM_A_MASK) ? wdata[`PMM_NEV-1:0] : mask_q));
      rdata <= 32'h0;
      if (rd) begin
        case (addr)
          `PMM_A_STAT:  rdata <= {29'h0, stat_q};
          `PMM_A_MASK:  rdata <= {29'h0, mask_q};
          `PMM_A_SR:    rdata <= {16'h0, sr_q};
          `PMM_A_USP:   rdata <= usp_q;
          `PMM_A_IMASK: rdata <= {29'h0, ebi_int_mask};
          `PMM_A_SFC:   rdata <= {29'h0, sfc_q};
          `PMM_A_DFC:   rdata <= {29'h0, dfc_q};
          `PMM_A_VBR:   rdata <= vbr_q;
          default:      rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

/* File: test/pmm_core_monitor.sv */
// assertion checker for the privileged move / multiply unit ports
`include "pmm_consts.vh"
module pmm_core_monitor (
  input wire        clock,
  input wire        rst,
  input wire        issue,
  input wire [4:0]  op,
  input wire        wake,
  input wire        mem_ack,
  input wire        mem_req,
  input wire        mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire        busy,
  input wire        trap,
  input wire        stopped
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // a trap is one pulse, caused by an issue taken while idle
  AST_TRAP_PULSE: assert property (trap |=> !trap)
    else $error("trap longer than one cycle");
  AST_TRAP_CAUSE: assert property (trap |-> $past(issue) && !$past(busy))
    else $error("trap without a taken issue");
  // a refused instruction starts no memory cycle and no busy period
  AST_TRAP_QUIET: assert property (trap |-> !mem_req && !busy)
    else $error("trapped instruction went on");
  // the request and its address, direction and write data stay put until the answer
  AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  AST_BUSY_END: assert property (busy |-> ##[0:300] !busy)
    else $error("busy never ended");
  // stop comes only from the stop instruction and halts bus traffic
  AST_STOP_CAUSE: assert property ($rose(stopped) |-> $past(op) == `PMM_OP_LOW_POWER_STOP && !trap)
    else $error("stop entered by another opcode");
  AST_STOP_NO_MEM: assert property (stopped |-> !mem_req)
    else $error("memory request while stopped");
  AST_WAKE: assert property (stopped && wake |-> ##[1:4] !stopped)
    else $error("wake did not leave stop");
endmodule
bind pmm_core pmm_core_monitor u_mon (.clock(clock), .rst(rst), .issue(issue), .op(op), .wake(wake),
  .mem_ack(mem_ack), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .busy(busy), .trap(trap), .stopped(stopped));

/* File: test/pmm_mem_model.sv */
// memory and bus partner answering the unit's memory requests
module pmm_mem_model (
  input  wire         clock,
  input  wire         rst,
  input  wire  [1:0]  lat,
  input  wire         mem_req,
  input  wire         mem_we,
  input  wire  [31:0] mem_addr,
  input  wire  [31:0] mem_wdata,
  input  wire  [2:0]  mem_fc,
  output logic        mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:255];
  logic [2:0]  fc;
  logic [1:0]  cnt;
  // ack after lat wait cycles; read data toggles outside the ack cycle so stale data never matches
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      cnt <= 2'h0;
      fc <= 3'h0;
    end else if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (cnt != lat) begin
      cnt <= cnt + 2'h1;
      mem_rdata <= ~mem_rdata;
    end else begin
      mem_ack <= 1'b1;
      cnt <= 2'h0;
      fc <= mem_fc;
      if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[9:2]];
    end
  end
endmodule

/* File: test/test_pmm_core.sv */
// self-checking bench for the privileged move / multiply unit
`include "pmm_consts.vh"
module test_pmm_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rst = 1'b1, issue = 1'b0, use_imm = 1'b0, ea_is_reg = 1'b0;
  logic        wake = 1'b0, wr = 1'b0, rd = 1'b0, eir = 1'b0, tr;
  logic [4:0]  op = 5'h00;
  logic [3:0]  reg_a = 4'h0, reg_b = 4'h0, addr = 4'h0;
  logic [1:0]  size = 2'h2, lat = 2'h0;
  logic [31:0] imm = 32'h0, ea = 32'h0, wdata = 32'h0;
  logic [15:0] reg_list = 16'h0;
  logic        mem_ack, mem_req, mem_we, busy, trap, stopped, irq;
  logic [31:0] mem_rdata, mem_addr, mem_wdata, rdata;
  logic [2:0]  mem_fc, ebi_int_mask;
  logic [63:0] p;
  logic [4:0]  pops [0:8] = '{`PMM_OP_LOW_POWER_STOP, `PMM_OP_RD_SR, `PMM_OP_WR_SR, `PMM_OP_RD_USP,
                              `PMM_OP_WR_USP, `PMM_OP_RD_CR, `PMM_OP_WR_CR, `PMM_OP_ALT_WR, `PMM_OP_ALT_RD};
  int          error_cnt = 0, n_tests = 0, n;
  // clk_en tied high: freezing is not exercised here
  pmm_core DUT (.clock(clock), .rst(rst), .clk_en(1'b1), .issue(issue), .op(op), .reg_a(reg_a),
    .reg_b(reg_b), .size(size), .use_imm(use_imm), .imm(imm), .ea(ea), .reg_list(reg_list),
    .ea_is_reg(ea_is_reg), .wake(wake), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_fc(mem_fc), .busy(busy),
    .trap(trap), .stopped(stopped), .ebi_int_mask(ebi_int_mask), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  pmm_mem_model u_mem (.clock(clock), .rst(rst), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_fc(mem_fc), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a used-up wait bound counts as a mismatch and ends the run
  task automatic tmo(input int lim);
    if (n >= lim) begin
      error_cnt++;
      finish_test();
    end
  endtask
  // issue one instruction, then wait until idle or stopped
  task automatic ex(input logic [4:0] o, input logic [3:0] a, input logic [3:0] b, input logic ui,
                    input logic [31:0] im, input logic [31:0] e = 32'h0, input logic [15:0] l = 16'h0);
    @(posedge clock);
    issue <= 1'b1;
    op <= o;
    reg_a <= a;
    reg_b <= b;
    use_imm <= ui;
    imm <= im;
    ea <= e;
    reg_list <= l;
    ea_is_reg <= eir;
    @(posedge clock);
    issue <= 1'b0;
    #1 tr = trap;
    for (n = 0; n < 400 && busy !== 1'b0 && stopped !== 1'b1; n++) #8;
    tmo(400);
  endtask
  task automatic q(input logic [3:0] b, input logic [7:0] v);
    ex(`PMM_OP_QUICK, 4'h0, b, 1'b1, {24'h0, v});
  endtask
  task automatic sw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  // irq is registered from the next status and mask values, so it updates with them; wait two edges
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clock);
    #1 chk(32'(irq), 32'(v));
  endtask
  task automatic t_arith();
    q(4'h2, 8'h25);
    q(4'h1, 8'h81);
    q(4'h0, 8'h04);
    eir = 1'b1;
    ex(`PMM_OP_DECIMAL_NEGATE, 4'h0, 4'h2, 1'b0, 32'h0);
    rchk(`PMM_A_SR, 32'h11, 32'h11);
    ex(`PMM_OP_LSL, 4'h0, 4'h1, 1'b1, 32'h0);
    ex(`PMM_OP_LSR, 4'h0, 4'h1, 1'b1, 32'h3);
    ex(`PMM_OP_LSR, 4'h0, 4'h1, 1'b0, 32'h0);
    eir = 1'b0;
    ex(`PMM_OP_DECIMAL_NEGATE, 4'h0, 4'h0, 1'b0, 32'h0, 32'hD0);
    chk(u_mem.mem[52], 32'h00000001);
    rchk(`PMM_A_SR, 32'h11, 32'h11);
    ex(`PMM_OP_MM_ST, 4'h0, 4'h0, 1'b0, 32'h0, 32'hC0, 16'h0006);
    chk(u_mem.mem[48], 32'h01FFFF02);
    chk(u_mem.mem[49], 32'h00000075);
  endtask
  // slow partner while loading and storing register sets
  task automatic t_mul();
    lat = 2'h2;
    ex(`PMM_OP_MM_LD, 4'h0, 4'h0, 1'b0, 32'h0, 32'h40, 16'h0018);
    q(4'h7, 8'hFE);
    ex(`PMM_OP_UNSIGNED_MULTIPLY_W, 4'h0, 4'h3, 1'b1, 32'h1234);
    ex(`PMM_OP_SIGNED_MULTIPLY_LL, 4'h5, 4'h4, 1'b1, 32'h3);
    ex(`PMM_OP_UNSIGNED_MULTIPLY_L, 4'h0, 4'h7, 1'b1, 32'h3);
    ex(`PMM_OP_MM_ST, 4'h0, 4'h0, 1'b0, 32'h0, 32'h80, 16'h00B8);
    p = $signed(32'hFFFF8001) * 64'sd3;
    chk(u_mem.mem[32], 32'h5678 * 32'h1234);
    chk(u_mem.mem[33], p[31:0]);
    chk(u_mem.mem[34], p[63:32]);
    chk(u_mem.mem[35], 32'hFFFFFFFA);
    lat = 2'h0;
  endtask
  task automatic t_priv();
    ex(`PMM_OP_MM_LD, 4'h0, 4'h0, 1'b0, 32'h0, 32'h48, 16'h0100);
    ex(`PMM_OP_WR_USP, 4'h8, 4'h0, 1'b0, 32'h0);
    rchk(`PMM_A_USP, 32'hFFFFFFFF, 32'hCAFE0010);
    ex(`PMM_OP_RD_USP, 4'h0, 4'h9, 1'b0, 32'h0);
    q(4'h6, 8'h05);
    ex(`PMM_OP_WR_CR, 4'h6, 4'h0, 1'b0, 32'h1);
    q(4'h6, 8'h03);
    ex(`PMM_OP_WR_CR, 4'h6, 4'h0, 1'b0, 32'h0);
    rchk(`PMM_A_DFC, 32'h7, 32'h5);
    ex(`PMM_OP_RD_CR, 4'h0, 4'hA, 1'b0, 32'h1);
    ex(`PMM_OP_ALT_WR, 4'hA, 4'h0, 1'b0, 32'h0, 32'hE0);
    chk(32'(u_mem.fc), 32'h5);
    ex(`PMM_OP_ALT_RD, 4'h0, 4'hB, 1'b0, 32'h0, 32'h40);
    chk(32'(u_mem.fc), 32'h3);
    ex(`PMM_OP_MM_ST, 4'h0, 4'h0, 1'b0, 32'h0, 32'hA0, 16'h0E00);
    chk(u_mem.mem[40], 32'hCAFE0010);
    chk(u_mem.mem[41], 32'h5);
    chk(u_mem.mem[42], 32'h12345678);
    chk(u_mem.mem[56], 32'h5);
  endtask
  task automatic t_stop();
    sw(`PMM_A_MASK, 32'h2);
    ex(`PMM_OP_LOW_POWER_STOP, 4'h0, 4'h0, 1'b1, 32'h2300);
    chk(32'(stopped), 32'h1);
    chk(32'(ebi_int_mask), 32'h3);
    rchk(`PMM_A_SR, 32'hFFFF, 32'h2300);
    irq_is(1'b1);
    sw(`PMM_A_MASK, 32'h0);
    irq_is(1'b0);
    sw(`PMM_A_MASK, 32'h2);
    irq_is(1'b1);
    sw(`PMM_A_STAT, 32'h2);
    irq_is(1'b0);
    @(posedge clock);
    wake <= 1'b1;
    #1;
    for (n = 0; n < 8 && stopped !== 1'b0; n++) #8;
    tmo(8);
    @(posedge clock);
    wake <= 1'b0;
  endtask
  // drop to user state, then every privileged form must trap and change nothing
  task automatic t_user();
    ex(`PMM_OP_WR_SR, 4'h0, 4'h0, 1'b1, 32'h0000);
    rchk(`PMM_A_SR, 32'hFFFF, 32'h0000);
    foreach (pops[i]) begin
      ex(pops[i], 4'h1, 4'h9, 1'b1, 32'h2701, 32'hF0);
      chk(32'(tr), 32'h1);
    end
    rchk(`PMM_A_SR, 32'hFFFF, 32'h0000);
    rchk(`PMM_A_USP, 32'hFFFFFFFF, 32'hCAFE0010);
    rchk(`PMM_A_DFC, 32'h7, 32'h5);
    rchk(`PMM_A_STAT, 32'h1, 32'h1);
    chk(32'(ebi_int_mask), 32'h3);
    chk(u_mem.mem[60], 32'h0BADF00D);
    ex(`PMM_OP_MM_ST, 4'h0, 4'h0, 1'b0, 32'h0, 32'hB0, 16'h0200);
    chk(u_mem.mem[44], 32'hCAFE0010);
    rchk(4'hF, 32'hFFFFFFFF, 32'h0);
  endtask
  initial begin
    u_mem.mem[16] = 32'h12345678;
    u_mem.mem[17] = 32'hFFFF8001;
    u_mem.mem[18] = 32'hCAFE0010;
    u_mem.mem[60] = 32'h0BADF00D;
    u_mem.mem[52] = 32'h00000099;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rchk(`PMM_A_SR, 32'hFFFF, 32'h2700);
    rchk(`PMM_A_STAT, 32'h7, 32'h0);
    chk(32'(ebi_int_mask), 32'h7);
    t_arith();
    t_mul();
    t_priv();
    t_stop();
    t_user();
    finish_test();
  end
endmodule
